// file: logic/rcs_pkg.sv
// Shared constants and types for the remote register command interpreter
package rcs_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 8;
  localparam int MON_SLOTS = 6;
  localparam int SLOT_W = 3;
  localparam int REQ_W = 4;
  // Request bit positions in the packed request vector
  localparam int REQ_MON = 0;
  localparam int REQ_VOL = 1;
  localparam int REQ_NV = 2;
  localparam int REQ_INSTR = 3;
  // Monitor slot holding the second code
  localparam logic [SLOT_W-1:0] SLOT_SECOND = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;
  // Byte fields of the sixteen-bit words
  localparam int LO_MSB = 7;
  localparam int HI_LSB = 8;
  localparam int HI_MSB = 15;
  localparam int SIGN_BIT = 15;
  localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
  // Setpoint limits, units of 0.01 Hz
  localparam logic [WORD_W-1:0] FREQ_MAX_UNSIGNED = 16'h9C40;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] REPLY_OK = 16'h0000;
  localparam logic [WORD_W-1:0] REPLY_FREQ_RANGE = 16'h0003;
  // Alarm history depth and index field
  localparam int ALARM_W = 3;
  localparam logic [CODE_W-1:0] ALARM_DEPTH = 8'h08;
  // Settle time from reset release to station ready
  localparam int CLK_PERIOD_PS = 5000;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_W = 8;
  typedef enum logic [1:0] {
    KIND_MON,
    KIND_FREQ,
    KIND_INSTR
  } rcs_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MON_ISSUE,
    ST_MON_WAIT,
    ST_FREQ_ISSUE,
    ST_FREQ_WAIT,
    ST_INSTR_WAIT
  } rcs_state_t;
endpackage

// file: logic/rcs_req_edge.sv
// Edge detector for the request bits coming from the master
`timescale 1ns/10ps
module rcs_req_edge #(
  parameter int W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] prev_reg;

  // Previous level of each request bit
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= i_level;
    end
  end

  // Rising and falling edges
  assign o_rise = i_level & ~prev_reg;
  assign o_fall = ~i_level & prev_reg;
endmodule

// file: logic/rcs_core.sv
// Remote register command interpreter: monitor, frequency write, instruction execution
`timescale 1ns/10ps
module rcs_core
  import rcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [rcs_pkg::WORD_W-1:0] i_monitor_select_pair,
  input wire logic [rcs_pkg::WORD_W-1:0] i_frequency_setpoint,
  input wire logic [rcs_pkg::WORD_W-1:0] i_instruction_word,
  input wire logic [rcs_pkg::WORD_W-1:0] i_instruction_write_value,
  input wire logic [rcs_pkg::WORD_W-1:0] i_monitor_select_three,
  input wire logic [rcs_pkg::WORD_W-1:0] i_monitor_select_four,
  input wire logic [rcs_pkg::WORD_W-1:0] i_monitor_select_five,
  input wire logic [rcs_pkg::WORD_W-1:0] i_monitor_select_six,
  input wire logic [rcs_pkg::WORD_W-1:0] i_alarm_history_index,
  input wire logic i_monitor_request_bit,
  input wire logic i_volatile_freq_write_request,
  input wire logic i_nonvolatile_freq_write_request,
  input wire logic i_instruction_execute_request,
  input wire logic [rcs_pkg::WORD_W-1:0] i_speed_display_setting,
  input wire logic i_frequency_sign_selection,
  input wire logic [rcs_pkg::WORD_W-1:0] i_link_expansion_setting,
  input wire logic i_option_error,
  input wire logic [rcs_pkg::WORD_W-1:0] i_output_frequency,
  input wire logic i_drv_ack,
  input wire logic [rcs_pkg::WORD_W-1:0] i_drv_data,
  output logic o_drv_req,
  output rcs_pkg::rcs_kind_t o_drv_kind,
  output logic [rcs_pkg::WORD_W-1:0] o_drv_code,
  output logic [rcs_pkg::CODE_W-1:0] o_drv_ext,
  output logic [rcs_pkg::WORD_W-1:0] o_drv_data,
  output logic o_drv_nv,
  output logic o_drv_reverse,
  output logic o_drv_speed,
  output logic [rcs_pkg::ALARM_W-1:0] o_alarm_select,
  output logic o_alarm_select_valid,
  output logic [rcs_pkg::WORD_W-1:0] o_first_monitor_result,
  output logic [rcs_pkg::WORD_W-1:0] o_second_monitor_result,
  output logic [4*rcs_pkg::WORD_W-1:0] o_extra_monitor_result,
  output logic [rcs_pkg::WORD_W-1:0] o_reply_code,
  output logic o_monitor_active,
  output logic o_volatile_freq_write_done,
  output logic o_nonvolatile_freq_write_done,
  output logic o_instruction_done_bit,
  output logic o_station_ready_bit
);
  import rcs_pkg::*;

  logic [REQ_W-1:0] req_level;
  logic [REQ_W-1:0] req_rise;
  logic [REQ_W-1:0] req_fall;
  rcs_state_t state_reg;
  logic [SLOT_W-1:0] slot_reg;
  logic [CODE_W-1:0] mon_code_reg [MON_SLOTS];
  logic [WORD_W-1:0] result_reg [MON_SLOTS];
  logic [WORD_W-1:0] freq_val_reg;
  logic freq_nv_reg;
  logic [WORD_W-1:0] instr_word_reg;
  logic [WORD_W-1:0] instr_data_reg;
  logic mon_pend_reg;
  logic freq_pend_reg;
  logic instr_pend_reg;
  logic [INIT_W-1:0] init_cnt_reg;
  logic ready_reg;
  logic speed_mode;
  logic signed_mode;
  logic freq_fault;
  logic [WORD_W-1:0] freq_mag;
  logic freq_rev;
  logic mon_finish;
  logic freq_finish;
  logic instr_finish;
  logic mon_skip;

  assign req_level = {i_instruction_execute_request, i_nonvolatile_freq_write_request,
                      i_volatile_freq_write_request, i_monitor_request_bit};

  rcs_req_edge #(
    .W(REQ_W)
  ) u_req_edge (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_level(req_level),
    .o_rise(req_rise),
    .o_fall(req_fall)
  );

  // Setpoint interpretation for the current mode
  assign speed_mode = (i_speed_display_setting != WORD_ZERO);
  assign signed_mode = i_frequency_sign_selection && !speed_mode;
  always_comb begin
    freq_mag = freq_val_reg;
    freq_rev = 1'b0;
    freq_fault = 1'b0;
    if (signed_mode) begin
      freq_rev = freq_val_reg[SIGN_BIT];
      if (freq_val_reg[SIGN_BIT]) begin
        freq_mag = WORD_W'(~freq_val_reg + 16'h0001);
      end
    end else if (!speed_mode) begin
      freq_fault = (freq_val_reg > FREQ_MAX_UNSIGNED);
    end
  end

  // Completion strobes and skip of the live second monitor
  assign mon_finish = (state_reg == ST_MON_WAIT) && i_drv_ack && (slot_reg == SLOT_LAST);
  assign freq_finish = ((state_reg == ST_FREQ_WAIT) && i_drv_ack)
                       || ((state_reg == ST_FREQ_ISSUE) && freq_fault);
  assign instr_finish = (state_reg == ST_INSTR_WAIT) && i_drv_ack;
  assign mon_skip = (slot_reg == SLOT_SECOND) && (mon_code_reg[SLOT_SECOND] == CODE_NONE);

  // Snapshot of register words on a request rise while that request is not already pending
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < MON_SLOTS; i++) begin
        mon_code_reg[i] <= CODE_NONE;
      end
      freq_val_reg <= WORD_ZERO;
      freq_nv_reg <= 1'b0;
      instr_word_reg <= WORD_ZERO;
      instr_data_reg <= WORD_ZERO;
    end else begin
      if (req_rise[REQ_MON] && !mon_pend_reg) begin
        mon_code_reg[0] <= i_monitor_select_pair[LO_MSB:0];
        mon_code_reg[1] <= i_monitor_select_pair[HI_MSB:HI_LSB];
        mon_code_reg[2] <= i_monitor_select_three[LO_MSB:0];
        mon_code_reg[3] <= i_monitor_select_four[LO_MSB:0];
        mon_code_reg[4] <= i_monitor_select_five[LO_MSB:0];
        mon_code_reg[5] <= i_monitor_select_six[LO_MSB:0];
      end
      if ((req_rise[REQ_VOL] || req_rise[REQ_NV]) && !freq_pend_reg) begin
        freq_val_reg <= i_frequency_setpoint;
        freq_nv_reg <= req_rise[REQ_NV];
      end
      if (req_rise[REQ_INSTR] && !instr_pend_reg) begin
        instr_word_reg <= i_instruction_word;
        instr_data_reg <= i_instruction_write_value;
      end
    end
  end

  // Pending requests; a new rise wins over the service clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mon_pend_reg <= 1'b0;
      freq_pend_reg <= 1'b0;
      instr_pend_reg <= 1'b0;
    end else if (i_option_error || !ready_reg) begin
      mon_pend_reg <= 1'b0;
      freq_pend_reg <= 1'b0;
      instr_pend_reg <= 1'b0;
    end else begin
      if (req_rise[REQ_MON]) begin
        mon_pend_reg <= 1'b1;
      end else if (mon_finish) begin
        mon_pend_reg <= 1'b0;
      end
      if (req_rise[REQ_VOL] || req_rise[REQ_NV]) begin
        freq_pend_reg <= 1'b1;
      end else if (freq_finish) begin
        freq_pend_reg <= 1'b0;
      end
      if (req_rise[REQ_INSTR]) begin
        instr_pend_reg <= 1'b1;
      end else if (instr_finish) begin
        instr_pend_reg <= 1'b0;
      end
    end
  end

  // Sequencer serving monitor, then frequency, then instruction
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ST_IDLE;
      slot_reg <= '0;
    end else if (i_option_error) begin
      state_reg <= ST_IDLE;
      slot_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          slot_reg <= '0;
          if (mon_pend_reg) begin
            state_reg <= ST_MON_ISSUE;
          end else if (freq_pend_reg) begin
            state_reg <= ST_FREQ_ISSUE;
          end else if (instr_pend_reg) begin
            state_reg <= ST_INSTR_WAIT;
          end
        end
        ST_MON_ISSUE: begin
          if (mon_skip) begin
            slot_reg <= SLOT_W'(slot_reg + 3'h1);
          end else begin
            state_reg <= ST_MON_WAIT;
          end
        end
        ST_MON_WAIT: begin
          if (i_drv_ack) begin
            slot_reg <= SLOT_W'(slot_reg + 3'h1);
            state_reg <= (slot_reg == SLOT_LAST) ? ST_IDLE : ST_MON_ISSUE;
          end
        end
        ST_FREQ_ISSUE: begin
          state_reg <= freq_fault ? ST_IDLE : ST_FREQ_WAIT;
        end
        ST_FREQ_WAIT: begin
          if (i_drv_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_INSTR_WAIT: begin
          if (i_drv_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Request toward the drive controller
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drv_req <= 1'b0;
      o_drv_kind <= KIND_MON;
      o_drv_code <= WORD_ZERO;
      o_drv_ext <= CODE_NONE;
      o_drv_data <= WORD_ZERO;
      o_drv_nv <= 1'b0;
      o_drv_reverse <= 1'b0;
      o_drv_speed <= 1'b0;
    end else begin
      o_drv_req <= 1'b0;
      if (!i_option_error) begin
        if (state_reg == ST_MON_ISSUE && !mon_skip) begin
          o_drv_req <= 1'b1;
          o_drv_kind <= KIND_MON;
          o_drv_code <= {CODE_NONE, mon_code_reg[slot_reg]};
        end else if (state_reg == ST_FREQ_ISSUE && !freq_fault) begin
          o_drv_req <= 1'b1;
          o_drv_kind <= KIND_FREQ;
          o_drv_data <= freq_mag;
          o_drv_nv <= freq_nv_reg;
          o_drv_reverse <= freq_rev;
          o_drv_speed <= speed_mode;
        end else if (state_reg == ST_IDLE && !mon_pend_reg && !freq_pend_reg
                     && instr_pend_reg) begin
          o_drv_req <= 1'b1;
          o_drv_kind <= KIND_INSTR;
          o_drv_data <= instr_data_reg;
          if (i_link_expansion_setting != WORD_ZERO) begin
            o_drv_code <= {CODE_NONE, instr_word_reg[LO_MSB:0]};
            o_drv_ext <= instr_word_reg[HI_MSB:HI_LSB];
          end else begin
            o_drv_code <= instr_word_reg;
            o_drv_ext <= CODE_NONE;
          end
        end
      end
    end
  end

  // Monitor results; second follows output frequency when its code is zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < MON_SLOTS; i++) begin
        result_reg[i] <= WORD_ZERO;
      end
    end else if (i_option_error) begin
      for (int i = 0; i < MON_SLOTS; i++) begin
        result_reg[i] <= WORD_ZERO;
      end
    end else begin
      if (state_reg == ST_MON_WAIT && i_drv_ack) begin
        result_reg[slot_reg] <= i_drv_data;
      end
      if (i_monitor_select_pair[HI_MSB:HI_LSB] == CODE_NONE) begin
        result_reg[SLOT_SECOND] <= i_output_frequency;
      end
    end
  end

  assign o_first_monitor_result = result_reg[0];
  assign o_second_monitor_result = result_reg[1];
  assign o_extra_monitor_result = {result_reg[5], result_reg[4], result_reg[3], result_reg[2]};

  // Reply code for frequency writes and instructions
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reply_code <= REPLY_OK;
    end else if (i_option_error) begin
      o_reply_code <= REPLY_OK;
    end else if (state_reg == ST_FREQ_ISSUE && freq_fault) begin
      o_reply_code <= REPLY_FREQ_RANGE;
    end else if ((state_reg == ST_FREQ_WAIT || state_reg == ST_INSTR_WAIT) && i_drv_ack) begin
      o_reply_code <= i_drv_data;
    end
  end

  // Handshake bits back to the master
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_monitor_active <= 1'b0;
      o_volatile_freq_write_done <= 1'b0;
      o_nonvolatile_freq_write_done <= 1'b0;
      o_instruction_done_bit <= 1'b0;
    end else if (i_option_error) begin
      o_monitor_active <= 1'b0;
      o_volatile_freq_write_done <= 1'b0;
      o_nonvolatile_freq_write_done <= 1'b0;
      o_instruction_done_bit <= 1'b0;
    end else begin
      if (!i_monitor_request_bit) begin
        o_monitor_active <= 1'b0;
      end else if (mon_finish) begin
        o_monitor_active <= 1'b1;
      end
      if (!i_volatile_freq_write_request) begin
        o_volatile_freq_write_done <= 1'b0;
      end else if (freq_finish && !freq_nv_reg) begin
        o_volatile_freq_write_done <= 1'b1;
      end
      if (!i_nonvolatile_freq_write_request) begin
        o_nonvolatile_freq_write_done <= 1'b0;
      end else if (freq_finish && freq_nv_reg) begin
        o_nonvolatile_freq_write_done <= 1'b1;
      end
      if (!i_instruction_execute_request) begin
        o_instruction_done_bit <= 1'b0;
      end else if (instr_finish) begin
        o_instruction_done_bit <= 1'b1;
      end
    end
  end

  // Initial setting count and station ready
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      init_cnt_reg <= '0;
      ready_reg <= 1'b0;
      o_station_ready_bit <= 1'b0;
    end else begin
      if (init_cnt_reg != INIT_W'(INIT_CYCLES)) begin
        init_cnt_reg <= INIT_W'(init_cnt_reg + 8'h01);
      end
      ready_reg <= (init_cnt_reg == INIT_W'(INIT_CYCLES));
      o_station_ready_bit <= ready_reg && !i_option_error;
    end
  end

  // Alarm history selection; indexes eight and above give undefined data
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm_select <= '0;
      o_alarm_select_valid <= 1'b0;
    end else begin
      o_alarm_select <= i_alarm_history_index[HI_LSB+ALARM_W-1:HI_LSB];
      o_alarm_select_valid <= (i_alarm_history_index[HI_MSB:HI_LSB] < ALARM_DEPTH);
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_freq_issue_signed_neg;
    (state_reg == ST_FREQ_ISSUE) && !freq_fault && signed_mode && freq_val_reg[SIGN_BIT]
      && !i_option_error;
  endsequence

  sequence s_instr_ack_held;
    instr_finish && i_instruction_execute_request && !i_option_error;
  endsequence

  a_mon_result_active: assert property ($rose(o_monitor_active) |-> $past(i_monitor_request_bit)
    && $past(mon_finish)) else $error("monitor active without completion");
  a_mon_active_drop: assert property (req_fall[REQ_MON] |=> !o_monitor_active)
    else $error("monitor active kept after request drop");
  a_nv_store_flag: assert property (o_drv_req && o_drv_kind == KIND_FREQ
    |-> o_drv_nv == freq_nv_reg) else $error("storage target mismatch");
  a_vol_done_cause: assert property ($rose(o_volatile_freq_write_done)
    |-> $past(freq_finish) && !freq_nv_reg) else $error("volatile done w/o write");
  a_range_fault_reply: assert property ((state_reg == ST_FREQ_ISSUE) && freq_fault
    && !i_option_error |=> o_reply_code == REPLY_FREQ_RANGE && !o_drv_req)
    else $error("out of range setpoint accepted");
  a_signed_reverse: assert property (s_freq_issue_signed_neg
    |=> o_drv_req && o_drv_reverse && (!o_drv_data[SIGN_BIT] || o_drv_data == 16'h8000))
    else $error("negative setpoint not reversed");
  a_speed_units: assert property ((state_reg == ST_FREQ_ISSUE) && speed_mode
    && !i_option_error |=> o_drv_speed && o_drv_data == $past(freq_val_reg))
    else $error("speed mode not passed");
  a_instr_done_set: assert property (s_instr_ack_held |=> o_instruction_done_bit)
    else $error("instruction done missing");
  a_instr_done_hold: assert property (o_instruction_done_bit && !i_instruction_execute_request
    |=> !o_instruction_done_bit) else $error("instruction done stuck");
  a_nv_done_clear: assert property (!i_nonvolatile_freq_write_request
    |=> !o_nonvolatile_freq_write_done) else $error("nv done not cleared");
  a_error_forces_off: assert property (i_option_error |=> !o_station_ready_bit
    && !o_monitor_active && !o_instruction_done_bit && o_first_monitor_result == WORD_ZERO)
    else $error("outputs live during option error");
  a_ready_after_init: assert property ($rose(o_station_ready_bit)
    |-> $past(init_cnt_reg, 2) == INIT_W'(INIT_CYCLES)) else $error("ready too early");
endmodule

// file: dv/rcs_drive_model.sv
// Drive controller model answering the interpreter's requests
`timescale 1ns/10ps
module rcs_drive_model
  import rcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_drv_req,
  input wire rcs_pkg::rcs_kind_t i_drv_kind,
  input wire logic [rcs_pkg::WORD_W-1:0] i_drv_code,
  input wire logic i_slow,
  output logic o_drv_ack,
  output logic [rcs_pkg::WORD_W-1:0] o_drv_data
);
  logic busy_reg;
  logic [3:0] wait_reg;
  // One request at a time; prompt or stalled answer, data toggles on every cycle without an answer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 1'b0;
      wait_reg <= 4'h0;
      o_drv_ack <= 1'b0;
      o_drv_data <= 16'h0000;
    end else if (busy_reg && wait_reg == 4'h0) begin
      busy_reg <= 1'b0;
      o_drv_ack <= 1'b1;
      o_drv_data <= (i_drv_kind == KIND_MON) ? {8'hD0, i_drv_code[7:0]} : REPLY_OK;
    end else begin
      o_drv_ack <= 1'b0;
      o_drv_data <= ~o_drv_data;
      if (i_drv_req) begin
        busy_reg <= 1'b1;
        wait_reg <= i_slow ? 4'h6 : 4'h0;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule

// file: dv/tb.sv
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module tb;
  import rcs_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] mpair = 16'h0, setp = 16'h0, instr = 16'h0, wval = 16'h0;
  logic [15:0] m3 = 16'h0011, m4 = 16'h0012, m5 = 16'h0013, m6 = 16'h0014;
  logic [15:0] alarm = 16'h0, speed = 16'h0, expn = 16'h0, ofreq = 16'h1111;
  logic [3:0] req = 4'h0;
  logic sign_sel = 1'b0, opt_err = 1'b0, slow = 1'b0;
  wire logic ack, dreq, dnv, drev, dspd, alarm_ok;
  wire logic [15:0] ddat_in, dcode, ddat, res1, res2, reply;
  wire logic [7:0] dext;
  wire logic [2:0] asel;
  wire logic [63:0] extra;
  wire logic [4:0] done;
  wire rcs_kind_t dkind;
  int n_errors = 0;
  int num_checks = 0;
  // Clock, 5 ns period
  initial begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  rcs_core dut_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_monitor_select_pair(mpair),
    .i_frequency_setpoint(setp), .i_instruction_word(instr), .i_instruction_write_value(wval),
    .i_monitor_select_three(m3), .i_monitor_select_four(m4), .i_monitor_select_five(m5),
    .i_monitor_select_six(m6), .i_alarm_history_index(alarm), .i_monitor_request_bit(req[0]),
    .i_volatile_freq_write_request(req[1]), .i_nonvolatile_freq_write_request(req[2]),
    .i_instruction_execute_request(req[3]), .i_speed_display_setting(speed),
    .i_frequency_sign_selection(sign_sel), .i_link_expansion_setting(expn),
    .i_option_error(opt_err), .i_output_frequency(ofreq), .i_drv_ack(ack), .i_drv_data(ddat_in),
    .o_drv_req(dreq), .o_drv_kind(dkind), .o_drv_code(dcode), .o_drv_ext(dext),
    .o_drv_data(ddat), .o_drv_nv(dnv), .o_drv_reverse(drev), .o_drv_speed(dspd),
    .o_alarm_select(asel), .o_alarm_select_valid(alarm_ok), .o_first_monitor_result(res1),
    .o_second_monitor_result(res2), .o_extra_monitor_result(extra), .o_reply_code(reply),
    .o_monitor_active(done[0]), .o_volatile_freq_write_done(done[1]),
    .o_nonvolatile_freq_write_done(done[2]), .o_instruction_done_bit(done[3]),
    .o_station_ready_bit(done[4]));
  rcs_drive_model drv_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_drv_req(dreq),
    .i_drv_kind(dkind), .i_drv_code(dcode), .i_slow(slow), .o_drv_ack(ack), .o_drv_data(ddat_in));
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp, input string what);
    check16({15'h0, got}, {15'h0, exp}, what);
  endtask
  // Bounded wait for a status bit to reach a level
  task automatic wait_for(input int ix, input logic lvl);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge i_clk_sys);
      #1;
      if (done[ix] === lvl) break;
    end
    if (k == 400) begin
      n_errors++;
      $display("ERROR %0t wait ran out", $time);
      complete_run();
    end
  endtask
  // Raise a request after its words were set, wait for completion
  task automatic run(input int ix);
    @(posedge i_clk_sys);
    req[ix] <= 1'b1;
    wait_for(ix, 1'b1);
  endtask
  task automatic finish(input int ix);
    @(posedge i_clk_sys);
    req[ix] <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check1(done[ix], 1'b0, "done kept");
  endtask
  task automatic t_monitor();
    slow <= 1'b1;
    mpair <= 16'h0302;
    run(0);
    check16(res1, 16'hD002, "first");
    check16(res2, 16'hD003, "second");
    for (int k = 0; k < 4; k++) begin
      check16(extra[16*k +: 16], 16'hD011 + 16'(k), "extra");
    end
    finish(0);
    mpair <= 16'h0002;
    run(0);
    check16(res2, 16'h1111, "live second");
    finish(0);
    slow <= 1'b0;
    $display("test monitor done");
  endtask
  task automatic freq_op(input int ix, input logic [15:0] v, d, rp, input logic nv, rv, sp);
    setp <= v;
    run(ix);
    check16(reply, rp, "reply");
    check1(done[3-ix], 1'b0, "other done");
    if (rp === REPLY_OK) begin
      check16(ddat, d, "magnitude");
      check1(dnv, nv, "nonvolatile");
      check1(drev, rv, "reverse");
      check1(dspd, sp, "speed");
    end
    finish(ix);
  endtask
  task automatic t_freq();
    freq_op(1, 16'h9C40, 16'h9C40, REPLY_OK, 1'b0, 1'b0, 1'b0);
    freq_op(2, 16'h9C41, 16'h0000, REPLY_FREQ_RANGE, 1'b1, 1'b0, 1'b0);
    freq_op(2, 16'h0001, 16'h0001, REPLY_OK, 1'b1, 1'b0, 1'b0);
    sign_sel <= 1'b1;
    freq_op(1, 16'hFF9C, 16'h0064, REPLY_OK, 1'b0, 1'b1, 1'b0);
    freq_op(1, 16'h7FFF, 16'h7FFF, REPLY_OK, 1'b0, 1'b0, 1'b0);
    speed <= 16'h0001;
    freq_op(2, 16'hC350, 16'hC350, REPLY_OK, 1'b1, 1'b0, 1'b1);
    sign_sel <= 1'b0;
    speed <= 16'h0000;
    $display("test frequency done");
  endtask
  task automatic t_instr();
    expn <= 16'h0001;
    instr <= 16'h1234;
    wval <= 16'h5678;
    run(3);
    check16({8'h00, dext}, 16'h0012, "ext");
    check16(dcode, 16'h0034, "low code");
    check16(ddat, 16'h5678, "data");
    check16({14'h0, dkind}, 16'h0002, "kind");
    repeat (5) @(posedge i_clk_sys);
    #1;
    check1(done[3], 1'b1, "held");
    finish(3);
    expn <= 16'h0000;
    instr <= 16'h0300;
    wval <= 16'h0000;
    run(3);
    check16(dcode, 16'h0300, "code");
    check16({8'h00, dext}, 16'h0000, "no ext");
    finish(3);
    $display("test instruction done");
  endtask
  task automatic t_alarm();
    alarm <= 16'h0700;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check16({13'h0, asel}, 16'h0007, "alarm");
    check1(alarm_ok, 1'b1, "alarm ok");
    alarm <= 16'h0800;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check1(alarm_ok, 1'b0, "alarm high");
    $display("test alarm done");
  endtask
  task automatic t_error();
    setp <= 16'h0100;
    run(1);
    opt_err <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check1(done[1], 1'b0, "forced");
    check1(done[4], 1'b0, "ready off");
    check16(res1, WORD_ZERO, "result off");
    opt_err <= 1'b0;
    req[1] <= 1'b0;
    wait_for(4, 1'b1);
    $display("test option error done");
  endtask
  // Reset, settle, scenarios
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (150) @(posedge i_clk_sys);
    #1;
    check1(done[4], 1'b0, "early ready");
    wait_for(4, 1'b1);
    t_monitor();
    t_freq();
    t_instr();
    t_alarm();
    t_error();
    complete_run();
  end
endmodule
